// ==== hdl/deab_pkg.sv ====
// package: constants and carriers for the display erase and autoblanking block
package deab_pkg;

  // ---------------------------------------------------------------
  // clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned FIELD_HZ      = 60;
  // intervals given in milliseconds, counted in video fields
  localparam int unsigned DETECT_MS     = 500;
  localparam int unsigned LOSS_MS       = 1500;
  localparam int unsigned NODATA_MS     = 16000;
  localparam logic [15:0] DETECT_FIELDS = 16'((DETECT_MS * FIELD_HZ + 999) / 1000);
  localparam logic [15:0] LOSS_FIELDS   = 16'((LOSS_MS * FIELD_HZ + 999) / 1000);
  localparam logic [15:0] NODATA_FIELDS = 16'((NODATA_MS * FIELD_HZ + 999) / 1000);
  localparam int unsigned RUNIN_CYCLES  = 7;

  // ---------------------------------------------------------------
  // display modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    caption_channel_one = 4'h0,
    caption_channel_two,
    caption_channel_three,
    caption_channel_four,
    text_channel_one,
    text_channel_two,
    text_channel_three,
    text_channel_four,
    full_info_display_mode,
    graze_info_display_mode,
    user_osd_mode
  } deab_mode_e;

  // ---------------------------------------------------------------
  // register map (AXI4-Lite byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] COUNT_ADDR  = 8'h08;
  // control fields
  localparam int unsigned CTRL_MODE_LSB    = 0;
  localparam int unsigned CTRL_DEC_ON_BIT  = 4;
  localparam int unsigned CTRL_NODATA_BIT  = 5;
  localparam logic [3:0]  MODE_RESET       = 4'h0;
  localparam logic        DEC_ON_RESET     = 1'b0;
  localparam logic        NODATA_EN_RESET  = 1'b1;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // per-field line 21 report from the slicer
  typedef struct packed {
    logic       field_end;   // one-cycle pulse at the end of each field
    logic       field_two;   // field that just ended was field 2
    logic [2:0] runin_count; // run-in cycles seen on line 21
    logic       start_bit;   // start bit seen after the run-in
    logic       chan_data;   // data for the selected channel arrived
  } deab_field_s;

  // caption command strobes
  typedef struct packed {
    logic start_text;
    logic erase_displayed_memory_cmd;
    logic erase_offscreen_memory_cmd;
  } deab_cmd_s;

  // erase and blank controls to the display memories
  typedef struct packed {
    logic erase_onscreen;
    logic erase_offscreen;
    logic erase_keep_box;
    logic blank;
  } deab_erase_s;

endpackage : deab_pkg

// ==== hdl/deab_timer.sv ====
// field counter with restart, used for the detect, loss and no-data intervals
module deab_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        restart,
  input  wire logic        tick,
  input  wire logic [15:0] limit,
  output logic             done,
  output logic [15:0]      count
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // restart beats tick so a fresh trigger always starts from zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 16'h0000;
    end else if (restart) begin
      count <= 16'h0000;
    end else if (tick && count != limit) begin
      count <= count + 16'h0001;
    end
  end

  assign done = (count == limit);

endmodule : deab_timer

// ==== hdl/deab_top.sv ====
// display erase and autoblanking control with AXI4-Lite registers
// How it works
// - start text clears characters, keeps box; here only in text modes
// - erase displayed command clears on-screen caption memory
// - erase offscreen command clears off-screen memory only
// - display mode change clears display memory
// - video lock loss clears screen, mode kept
// - watch waveform only in selected channel's field
// - decoder held off until 0.5 s detection
// - display shown only when decoder on
// - blank after 1.5 s waveform absence
// - any waveform restarts the loss count; here only a valid waveform in the selected field does
// - valid waveform is seven run-in plus start
// - no-data timer only in caption or info modes
// - 16 s without channel data erases on-screen
// - no-data erase keeps mode and decoder on
// - no-data timer enabled at reset, software disables
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
module deab_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // slicer and command decoder
  input  deab_pkg::deab_field_s     field_in,
  input  deab_pkg::deab_cmd_s       cmd_in,
  input  wire logic                 video_locked,
  // display memory controls
  output deab_pkg::deab_erase_s     erase_out,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // field that carries a mode's data: ch1/2 and text1/2 on field 1
  function automatic logic mode_field_two(input logic [3:0] m);
    mode_field_two = !(m == 4'h0 || m == 4'h1 || m == 4'h4 || m == 4'h5);
  endfunction : mode_field_two

  // caption channels and the two info-service templates
  function automatic logic mode_caption_or_info(input logic [3:0] m);
    mode_caption_or_info = (m <= 4'h3) || (m == 4'h8) || (m == 4'h9);
  endfunction : mode_caption_or_info

  function automatic logic mode_is_text(input logic [3:0] m);
    mode_is_text = (m >= 4'h4) && (m <= 4'h7);
  endfunction : mode_is_text

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [3:0] mode;
  logic       decoder_on;
  logic       nodata_en;
  logic       mode_change;
  logic       lock_d;

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  // address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response: unmapped or read-only addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= deab_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == deab_pkg::CTRL_ADDR) ? deab_pkg::RESP_OKAY
                                                       : deab_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control register: only byte lane 0 holds fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode        <= deab_pkg::MODE_RESET;
      decoder_on  <= deab_pkg::DEC_ON_RESET;
      nodata_en   <= deab_pkg::NODATA_EN_RESET;
      mode_change <= 1'b0;
    end else begin
      mode_change <= 1'b0;
      if (do_write && aw_addr == deab_pkg::CTRL_ADDR && w_strb[0]) begin
        // codes above the last mode are ignored, mode stays
        if (w_data[deab_pkg::CTRL_MODE_LSB +: 4] <= 4'hA) begin
          mode        <= w_data[deab_pkg::CTRL_MODE_LSB +: 4];
          mode_change <= (w_data[deab_pkg::CTRL_MODE_LSB +: 4] != mode);
        end
        decoder_on <= w_data[deab_pkg::CTRL_DEC_ON_BIT];
        nodata_en  <= w_data[deab_pkg::CTRL_NODATA_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // waveform qualification
  // ---------------------------------------------------------------
  logic field_match;
  logic wave_valid;
  logic sel_tick;

  // only the field of the selected channel is examined
  assign field_match = (field_in.field_two == mode_field_two(mode));
  assign sel_tick    = field_in.field_end && field_match;
  assign wave_valid  = sel_tick && field_in.start_bit
                       && (field_in.runin_count == 3'(deab_pkg::RUNIN_CYCLES));

  // ---------------------------------------------------------------
  // autoblank state machine
  // ---------------------------------------------------------------
  typedef enum logic { ab_blanked, ab_shown } deab_ab_e;
  deab_ab_e    ab_state;
  logic        detect_done;
  logic        loss_done;
  logic        nodata_done;
  logic [15:0] detect_count;
  logic [15:0] loss_count;
  logic [15:0] nodata_count;
  logic        nodata_fired;
  logic        lock_lost;
  logic        autoblank_erase;

  assign lock_lost = lock_d && !video_locked;

  // detect needs an unbroken run; a missed field or lock loss restarts it
  deab_timer u_detect (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart ((sel_tick && !wave_valid) || !video_locked || mode_change
              || ab_state == ab_shown),
    .tick    (wave_valid),
    .limit   (deab_pkg::DETECT_FIELDS),
    .done    (detect_done),
    .count   (detect_count)
  );

  // a valid waveform in the selected field restarts the loss count
  deab_timer u_loss (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (wave_valid || ab_state == ab_blanked),
    .tick    (sel_tick),
    .limit   (deab_pkg::LOSS_FIELDS),
    .done    (loss_done),
    .count   (loss_count)
  );

  // the no-data timer idles outside caption and info modes
  deab_timer u_nodata (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (field_in.chan_data || !nodata_en
              || !mode_caption_or_info(mode) || mode_change),
    .tick    (sel_tick),
    .limit   (deab_pkg::NODATA_FIELDS),
    .done    (nodata_done),
    .count   (nodata_count)
  );

  // autoblank engages after the full loss interval, or at once on video lock loss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ab_state <= ab_blanked;
    end else begin
      unique case (ab_state)
        ab_blanked: if (detect_done && video_locked) ab_state <= ab_shown;
        ab_shown:   if (loss_done || lock_lost) ab_state <= ab_blanked;
      endcase
    end
  end

  assign autoblank_erase = (ab_state == ab_shown) && loss_done;

  // one erase per silent spell; mode and decoder flag left alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nodata_fired <= 1'b0;
      lock_d       <= 1'b0;
    end else begin
      lock_d <= video_locked;
      if (!nodata_done) nodata_fired <= 1'b0;
      else              nodata_fired <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // erase and blank outputs
  // ---------------------------------------------------------------
  logic next_erase_on;
  logic next_erase_off;
  logic next_keep_box;

  // all on-screen sources fold into one pulse; mode never touched here
  always_comb begin
    next_erase_on  = (cmd_in.erase_displayed_memory_cmd && mode_caption_or_info(mode))
                     || mode_change
                     || lock_lost
                     || autoblank_erase
                     || (nodata_done && !nodata_fired);
    next_keep_box  = cmd_in.start_text && mode_is_text(mode) && !next_erase_on;
    next_erase_off = cmd_in.erase_offscreen_memory_cmd || mode_change;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_out <= '{erase_onscreen: 1'b0, erase_offscreen: 1'b0,
                     erase_keep_box: 1'b0, blank: 1'b1};
    end else begin
      erase_out.erase_onscreen  <= next_erase_on;
      erase_out.erase_offscreen <= next_erase_off;
      erase_out.erase_keep_box  <= next_keep_box;
      erase_out.blank           <= (ab_state != ab_shown) || !decoder_on;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // status shows the block's state and the video_locked input; one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= deab_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= deab_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        deab_pkg::CTRL_ADDR:   s_axi_rdata <= {26'h0, nodata_en, decoder_on, mode};
        deab_pkg::STATUS_ADDR: s_axi_rdata <= {28'h0, video_locked, nodata_done,
                                               loss_done, ab_state == ab_shown};
        deab_pkg::COUNT_ADDR:  s_axi_rdata <= {detect_count, nodata_count};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= deab_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : deab_top

// ==== sim/deab_slicer_model.sv ====
// model of the line 21 slicer feeding per-field reports
module deab_slicer_model (
  input  wire logic            aclk,
  input  wire logic            wave_ok,
  input  wire logic            in_f2,
  input  wire logic            data_on,
  output deab_pkg::deab_field_s field_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase;

  initial begin
    phase    = 1'b0;
    field_in = '0;
  end

  // ------------------------------------------------------------
  // one field report every second cycle
  // ------------------------------------------------------------
  // between reports field_two, runin_count and start_bit are scrambled, so a design reading them
  // outside field_end picks up garbage instead of a friendly hold; chan_data stays low
  always @(posedge aclk) begin
    phase                <= ~phase;
    field_in.field_end   <= phase;
    field_in.field_two   <= phase ? in_f2 : ~in_f2;
    field_in.runin_count <= phase ? (wave_ok ? 3'h7 : 3'h6) : 3'h0;
    field_in.start_bit   <= phase ? wave_ok : ~field_in.start_bit;
    field_in.chan_data   <= phase & data_on;
  end
endmodule : deab_slicer_model

// ==== sim/deab_top_asserts.sv ====
// checker: port-level properties of the erase and autoblank block
module deab_top_asserts (
  input wire logic             aclk,
  input wire logic             aresetn,
  input deab_pkg::deab_field_s field_in,
  input deab_pkg::deab_cmd_s   cmd_in,
  input wire logic             video_locked,
  input deab_pkg::deab_erase_s erase_out,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // erase and blank
  // ------------------------------------------------------------
  a_lock_erase: assert property ($fell(video_locked)
    |=> erase_out.erase_onscreen ##1 erase_out.blank) else $error("lock loss not erased");
  a_offscr_cmd: assert property (cmd_in.erase_offscreen_memory_cmd
    |=> erase_out.erase_offscreen) else $error("offscreen erase missing");
  a_offscr_cause: assert property (erase_out.erase_offscreen
    |-> $past(cmd_in.erase_offscreen_memory_cmd) || $past(s_axi_bvalid))
    else $error("stray offscreen erase");
  a_onscr_single: assert property (erase_out.erase_onscreen
    |=> !erase_out.erase_onscreen) else $error("onscreen erase longer than one cycle");
  a_box_single: assert property (erase_out.erase_keep_box
    |=> !erase_out.erase_keep_box) else $error("box erase longer than one cycle");
  // showing only follows a field report or a control write
  a_show_at_field: assert property ($fell(erase_out.blank)
    |-> $past(field_in.field_end, 3) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("display shown without cause");
  a_blank_cause: assert property ($rose(erase_out.blank)
    |-> $past(erase_out.erase_onscreen) || s_axi_bvalid || $past(s_axi_bvalid))
    else $error("blank without erase");

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  a_b_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open during bvalid");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");

  c_show: cover property ($fell(erase_out.blank));
  c_box: cover property (erase_out.erase_keep_box);
  c_lock: cover property ($fell(video_locked) ##1 erase_out.erase_onscreen);
endmodule : deab_top_asserts

bind deab_top deab_top_asserts deab_top_asserts_i (.aclk(aclk), .aresetn(aresetn),
  .field_in(field_in), .cmd_in(cmd_in), .video_locked(video_locked), .erase_out(erase_out),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ==== sim/tb_top.sv ====
// testbench for the erase and autoblank block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  aclk, aresetn, video_locked, wave_ok, in_f2, data_on;
  deab_pkg::deab_field_s field_in;
  deab_pkg::deab_cmd_s   cmd_in;
  deab_pkg::deab_erase_s erase_out;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  int                    err_count, tests_run, cyc, on_cnt, off_cnt, box_cnt, on0, off0, box0;

  deab_top deab_top_i (.aclk(aclk), .aresetn(aresetn), .field_in(field_in), .cmd_in(cmd_in),
    .video_locked(video_locked), .erase_out(erase_out), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  deab_slicer_model deab_slicer_model_i (.aclk(aclk), .wave_ok(wave_ok), .in_f2(in_f2),
    .data_on(data_on), .field_in(field_in));

  always #2 aclk = ~aclk;

  // ------------------------------------------------------------
  // pulse counters and hang guard
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (erase_out.erase_onscreen === 1'b1) on_cnt++;
    if (erase_out.erase_offscreen === 1'b1) off_cnt++;
    if (erase_out.erase_keep_box === 1'b1) box_cnt++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask : chk

  task automatic snap;
    on0 = on_cnt;
    off0 = off_cnt;
    box0 = box_cnt;
  endtask : snap

  // one field report takes two cycles in the slicer model
  task automatic fw(input int n);
    repeat (2 * n) @(posedge aclk);
  endtask : fw

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
    // let an edge pass so a following call never reassigns bready in this step
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, e, "rdata");
    chk({30'h0, rresp}, {30'h0, er}, "rresp");
    // let an edge pass so a following call never reassigns rready in this step
    @(posedge aclk);
  endtask : rd

  task automatic cause(input deab_pkg::deab_cmd_s c, input logic lk);
    snap();
    cmd_in <= c; video_locked <= lk;
    @(posedge aclk);
    cmd_in <= '0;
    repeat (4) @(posedge aclk);
  endtask : cause

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(32'(erase_out.blank), 1, "blank at reset");
    rd(deab_pkg::CTRL_ADDR, 32'h20, deab_pkg::RESP_OKAY);
    rd(8'h0C, 0, deab_pkg::RESP_SLVERR);
    wr(deab_pkg::STATUS_ADDR, 1, deab_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset

  task automatic t_detect;
    wave_ok <= 1'b1; in_f2 <= 1'b1;
    fw(40);
    chk(32'(erase_out.blank), 1, "wrong field");
    in_f2 <= 1'b0;
    fw(28);
    chk(32'(erase_out.blank), 1, "early show");
    fw(10);
    chk(32'(erase_out.blank), 1, "shown with decoder off");
    wr(deab_pkg::CTRL_ADDR, 32'h30, deab_pkg::RESP_OKAY);
    fw(2);
    chk(32'(erase_out.blank), 0, "not shown");
    rd(deab_pkg::STATUS_ADDR, 32'h9, deab_pkg::RESP_OKAY);
    $display("test detect done");
  endtask : t_detect

  task automatic t_loss;
    snap();
    wave_ok <= 1'b0;
    fw(50);
    wave_ok <= 1'b1;
    fw(2);
    wave_ok <= 1'b0;
    fw(88);
    chk(32'(erase_out.blank), 0, "loss not restarted");
    chk(on_cnt - on0, 0, "early loss erase");
    fw(4);
    chk(32'(erase_out.blank), 1, "no blank after loss");
    chk(on_cnt - on0, 1, "loss erase count");
    $display("test loss done");
  endtask : t_loss

  task automatic t_cmds;
    cause(3'b010, 1'b1);
    chk(on_cnt - on0, 1, "displayed erase");
    cause(3'b001, 1'b1);
    chk(off_cnt - off0, 1, "offscreen erase");
    chk(on_cnt - on0, 0, "offscreen touched screen");
    cause(3'b100, 1'b1);
    chk(box_cnt - box0, 0, "start text in caption");
    cause(3'b010, 1'b0);
    chk(on_cnt - on0, 1, "merged erase");
    rd(deab_pkg::CTRL_ADDR, 32'h30, deab_pkg::RESP_OKAY);
    wr(deab_pkg::CTRL_ADDR, 32'h3F, deab_pkg::RESP_OKAY);
    rd(deab_pkg::CTRL_ADDR, 32'h30, deab_pkg::RESP_OKAY);
    cause(3'b000, 1'b1);
    snap();
    wr(deab_pkg::CTRL_ADDR, 32'h34, deab_pkg::RESP_OKAY);
    fw(2);
    chk(on_cnt - on0, 1, "mode change erase");
    cause(3'b100, 1'b1);
    chk(box_cnt - box0, 1, "start text erase");
    cause(3'b010, 1'b1);
    chk(on_cnt - on0, 0, "displayed erase in text");
    wr(deab_pkg::CTRL_ADDR, 32'h30, deab_pkg::RESP_OKAY);
    $display("test commands done");
  endtask : t_cmds

  task automatic t_nodata;
    wave_ok <= 1'b1; data_on <= 1'b1;
    fw(35);
    data_on <= 1'b0;
    snap();
    fw(980);
    chk(on_cnt - on0, 1, "no-data erase");
    rd(deab_pkg::STATUS_ADDR, 32'hD, deab_pkg::RESP_OKAY);
    rd(deab_pkg::COUNT_ADDR, {16'h0000, deab_pkg::NODATA_FIELDS}, deab_pkg::RESP_OKAY);
    rd(deab_pkg::CTRL_ADDR, 32'h30, deab_pkg::RESP_OKAY);
    wr(deab_pkg::CTRL_ADDR, 32'h10, deab_pkg::RESP_OKAY);
    data_on <= 1'b1;
    fw(2);
    data_on <= 1'b0;
    snap();
    fw(980);
    chk(on_cnt - on0, 0, "no-data erase while disabled");
    wr(deab_pkg::CTRL_ADDR, 32'h34, deab_pkg::RESP_OKAY);
    data_on <= 1'b1;
    fw(2);
    data_on <= 1'b0;
    snap();
    fw(980);
    chk(on_cnt - on0, 0, "no-data erase in text");
    $display("test nodata done");
  endtask : t_nodata

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  initial begin
    aclk = 0; aresetn = 0; video_locked = 1; wave_ok = 0; in_f2 = 0; data_on = 0;
    cmd_in = '0; awaddr = 0; araddr = 0; wdata = 0; wstrb = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    err_count = 0; tests_run = 0; cyc = 0; on_cnt = 0; off_cnt = 0; box_cnt = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_detect();
    t_loss();
    t_cmds();
    t_nodata();
    summarize();
  end
endmodule : tb_top
